// ===== shared/serial_port_pkg.sv
// Constants and types shared by the asynchronous serial port design
package serial_port_pkg;

  localparam int unsigned DIV_WIDTH   = 16;            // Bit-rate divider width
  localparam int unsigned OVERSAMPLE  = 16;            // Sample ticks per bit
  localparam logic [3:0]  TICK_MID    = 4'h7;          // Tick that samples mid-bit
  localparam logic [3:0]  TICK_LAST   = 4'hf;          // Last tick of a bit
  localparam logic [15:0] DIV_RESET   = 16'h0000;      // Divider value after reset
  localparam logic [7:0]  BYTE_RESET  = 8'h00;         // Data registers after reset

  // Parity selection codes
  localparam logic [1:0]  PARITY_NONE = 2'h0;
  localparam logic [1:0]  PARITY_ODD  = 2'h1;
  localparam logic [1:0]  PARITY_EVEN = 2'h2;

  // Frame phases, shared by transmitter and receiver
  typedef enum logic [4:0] {
    PH_IDLE   = 5'b00001,
    PH_START  = 5'b00010,
    PH_DATA   = 5'b00100,
    PH_PARITY = 5'b01000,
    PH_STOP   = 5'b10000
  } phase_e;

  // Parity over seven or eight data bits; odd parity makes the total count odd
  function automatic logic parity_of(input logic [7:0] data, input logic eight,
                                     input logic [1:0] mode);
    logic p;
    p = ^data[6:0] ^ (eight & data[7]);
    parity_of = (mode == PARITY_ODD) ? ~p : p;
  endfunction : parity_of

endpackage : serial_port_pkg

// ===== hw/bit_tick_gen.sv
// Programmable divider giving the oversampling tick from the system clock
module bit_tick_gen
(
  input  wire logic                                  clk_i,    // System clock
  input  wire logic                                  srst_i,   // Sync reset
  input  wire logic [serial_port_pkg::DIV_WIDTH-1:0] divisor_i, // Clocks per tick minus one
  output logic                                       tick_o    // One-cycle tick
);

  logic [serial_port_pkg::DIV_WIDTH-1:0] count;
  logic [serial_port_pkg::DIV_WIDTH-1:0] next_count;
  logic                                  next_tick;

  // Count down; a new divisor takes effect at the next reload, so a change of
  // system clock rate just shifts the bit rate until software reprograms it
  always_comb
  begin
    next_tick  = 1'b0;
    next_count = count - 1'b1;
    if (count == '0)
    begin
      next_tick  = 1'b1;
      next_count = divisor_i;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      count  <= serial_port_pkg::DIV_RESET;
      tick_o <= 1'b0;
    end
    else
    begin
      count  <= next_count;
      tick_o <= next_tick;
    end
  end

endmodule : bit_tick_gen

// ===== hw/async_serial_port.sv
// Full-duplex asynchronous serial port with double buffering and error flags
// Functional notes
// - Separate transmit and receive pins, sharing one tick divider and frame format
// - Seven or eight data bits, one or two stops
// - Odd, even or no parity
// - One holding buffer beside each shift register
// - Flag break, framing, parity and overrun errors
// - Error interrupt gated by software enable
// - Bit timing from programmable clock divider
// - No DMA request path at all
// - One interrupt: transmit done, receive, error
// - Bit rate follows clock until divider reprogrammed
module async_serial_port
(
  input  wire logic        clk_i,        // System clock
  input  wire logic        srst_i,       // Sync reset, active high
  input  wire logic [15:0] divisor_i,    // Tick divisor, bit = 16 ticks
  input  wire logic        eight_bit_i,  // 1: eight data bits, 0: seven
  input  wire logic [1:0]  parity_i,     // Parity mode code
  input  wire logic        two_stop_i,   // 1: two stop bits
  input  wire logic        err_irq_en_i, // Errors may raise the interrupt
  input  wire logic        tx_irq_en_i,  // Transmit complete may interrupt
  input  wire logic        rx_irq_en_i,  // Received character may interrupt
  input  wire logic [7:0]  tx_data_i,    // Byte to send
  input  wire logic        tx_write_i,   // Load tx_data_i into holding buffer
  output logic             tx_ready_o,   // Holding buffer free
  output logic             tx_done_o,    // Sticky: transmitter went idle
  input  wire logic        tx_done_clr_i, // Clear tx_done_o
  output logic             txd_o,        // Serial transmit pin
  input  wire logic        rxd_i,        // Serial receive pin
  output logic [7:0]       rx_data_o,    // Received byte, holding buffer
  output logic             rx_valid_o,   // Holding buffer full
  input  wire logic        rx_read_i,    // Software took rx_data_o
  output logic             brk_err_o,    // Sticky break flag
  output logic             frm_err_o,    // Sticky framing error
  output logic             par_err_o,    // Sticky parity error
  output logic             ovr_err_o,    // Sticky overrun error
  input  wire logic        err_clr_i,    // Clear all four error flags
  output logic             irq_o         // Combined interrupt request
);

  // Shared oversampling tick; no DMA request output exists by design
  logic tick;
  bit_tick_gen u_tick
  (
    .clk_i     (clk_i),
    .srst_i    (srst_i),
    .divisor_i (divisor_i),
    .tick_o    (tick)
  );

  // ---- Transmit state
  serial_port_pkg::phase_e tx_ph, next_tx_ph;
  logic [3:0] tx_tk, next_tx_tk;
  logic [2:0] tx_bit, next_tx_bit;
  logic       tx_stop2, next_tx_stop2;
  logic [7:0] tx_shift, next_tx_shift;
  logic [7:0] tx_hold, next_tx_hold;
  logic       tx_full, next_tx_full;
  logic       tx_par, next_tx_par;
  logic       next_txd, next_tx_done;

  // Transmit next state; stays on the tick so rate tracks the divider
  always_comb
  begin
    next_tx_ph    = tx_ph;
    next_tx_tk    = tx_tk;
    next_tx_bit   = tx_bit;
    next_tx_stop2 = tx_stop2;
    next_tx_shift = tx_shift;
    next_tx_hold  = tx_hold;
    next_tx_full  = tx_full;
    next_tx_par   = tx_par;
    next_txd      = txd_o;
    next_tx_done  = tx_done_o & ~tx_done_clr_i;
    if (tx_write_i && !tx_full)
    begin
      next_tx_hold = tx_data_i;
      next_tx_full = 1'b1;
    end
    case (tx_ph)
      serial_port_pkg::PH_IDLE:
      begin
        next_txd = 1'b1;
        if (tx_full)
        begin
          next_tx_shift = tx_hold;
          next_tx_par   = serial_port_pkg::parity_of(tx_hold, eight_bit_i, parity_i);
          next_tx_full  = 1'b0;
          next_tx_tk    = '0;
          next_txd      = 1'b0;
          next_tx_ph    = serial_port_pkg::PH_START;
        end
      end
      default:
      begin
        if (tick)
        begin
          next_tx_tk = tx_tk + 4'h1;
          if (tx_tk == serial_port_pkg::TICK_LAST)
          begin
            case (tx_ph)
              serial_port_pkg::PH_START:
              begin
                next_tx_ph  = serial_port_pkg::PH_DATA;
                next_tx_bit = '0;
                next_txd    = tx_shift[0];
              end
              serial_port_pkg::PH_DATA:
              begin
                next_tx_shift = {1'b1, tx_shift[7:1]};
                next_tx_bit   = tx_bit + 3'h1;
                next_txd      = tx_shift[1];
                if (tx_bit == {2'b11, eight_bit_i})
                begin
                  next_tx_stop2 = two_stop_i;
                  if (parity_i != serial_port_pkg::PARITY_NONE)
                  begin
                    next_tx_ph = serial_port_pkg::PH_PARITY;
                    next_txd   = tx_par;
                  end
                  else
                  begin
                    next_tx_ph = serial_port_pkg::PH_STOP;
                    next_txd   = 1'b1;
                  end
                end
              end
              serial_port_pkg::PH_PARITY:
              begin
                next_tx_ph = serial_port_pkg::PH_STOP;
                next_txd   = 1'b1;
              end
              serial_port_pkg::PH_STOP:
              begin
                if (tx_stop2)
                  next_tx_stop2 = 1'b0;
                else
                begin
                  next_tx_ph   = serial_port_pkg::PH_IDLE;
                  next_tx_done = 1'b1;
                end
              end
              default: next_tx_ph = serial_port_pkg::PH_IDLE;
            endcase
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      tx_ph     <= serial_port_pkg::PH_IDLE;
      tx_tk     <= '0;
      tx_bit    <= '0;
      tx_stop2  <= 1'b0;
      tx_shift  <= serial_port_pkg::BYTE_RESET;
      tx_hold   <= serial_port_pkg::BYTE_RESET;
      tx_full   <= 1'b0;
      tx_par    <= 1'b0;
      txd_o     <= 1'b1;
      tx_done_o <= 1'b0;
    end
    else
    begin
      tx_ph     <= next_tx_ph;
      tx_tk     <= next_tx_tk;
      tx_bit    <= next_tx_bit;
      tx_stop2  <= next_tx_stop2;
      tx_shift  <= next_tx_shift;
      tx_hold   <= next_tx_hold;
      tx_full   <= next_tx_full;
      tx_par    <= next_tx_par;
      txd_o     <= next_txd;
      tx_done_o <= next_tx_done;
    end
  end

  assign tx_ready_o = ~tx_full;

  // ---- Receive state; runs alongside transmit, sharing the tick divider and frame format
  serial_port_pkg::phase_e rx_ph, next_rx_ph;
  logic [3:0] rx_tk, next_rx_tk;
  logic [2:0] rx_bit, next_rx_bit;
  logic [7:0] rx_shift, next_rx_shift;
  logic       rx_zero, next_rx_zero;
  logic       rx_perr, next_rx_perr;
  logic       rx_prev, next_rx_prev;   // Line level one clock ago
  logic [7:0] next_rx_data;
  logic       next_rx_valid, next_brk, next_frm, next_par, next_ovr;
  logic [7:0] rx_byte;

  // Assembled byte, seven-bit frames keep bit 7 clear
  assign rx_byte = eight_bit_i ? rx_shift : {1'b0, rx_shift[7:1]};

  // Receive next state; flags set by hardware win over a same-cycle clear
  always_comb
  begin
    next_rx_ph    = rx_ph;
    next_rx_tk    = rx_tk;
    next_rx_bit   = rx_bit;
    next_rx_shift = rx_shift;
    next_rx_zero  = rx_zero;
    next_rx_perr  = rx_perr;
    next_rx_prev  = rxd_i;
    next_rx_data  = rx_data_o;
    next_rx_valid = rx_valid_o & ~rx_read_i;
    next_brk      = brk_err_o & ~err_clr_i;
    next_frm      = frm_err_o & ~err_clr_i;
    next_par      = par_err_o & ~err_clr_i;
    next_ovr      = ovr_err_o & ~err_clr_i;
    case (rx_ph)
      serial_port_pkg::PH_IDLE:
      begin
        // Falling edge only, so the low tail of a bad stop or break is no start
        if (rx_prev && !rxd_i)
        begin
          next_rx_ph = serial_port_pkg::PH_START;
          next_rx_tk = '0;
        end
      end
      default:
      begin
        if (tick)
        begin
          next_rx_tk = rx_tk + 4'h1;
          if (rx_tk == serial_port_pkg::TICK_MID)
          begin
            case (rx_ph)
              serial_port_pkg::PH_START:
              begin
                next_rx_tk   = '0; // Later samples land mid-bit
                next_rx_zero = 1'b1;
                next_rx_perr = 1'b0;
                next_rx_bit  = '0;
                // Glitch shorter than half a bit is ignored
                next_rx_ph   = rxd_i ? serial_port_pkg::PH_IDLE
                                     : serial_port_pkg::PH_DATA;
              end
              default: next_rx_ph = rx_ph;
            endcase
          end
          if (rx_tk == serial_port_pkg::TICK_LAST)
          begin
            next_rx_tk = '0;
            case (rx_ph)
              serial_port_pkg::PH_DATA:
              begin
                next_rx_shift = {rxd_i, rx_shift[7:1]};
                next_rx_zero  = rx_zero & ~rxd_i;
                next_rx_bit   = rx_bit + 3'h1;
                if (rx_bit == {2'b11, eight_bit_i})
                  next_rx_ph = (parity_i != serial_port_pkg::PARITY_NONE)
                               ? serial_port_pkg::PH_PARITY
                               : serial_port_pkg::PH_STOP;
              end
              serial_port_pkg::PH_PARITY:
              begin
                next_rx_zero = rx_zero & ~rxd_i;
                next_rx_perr = rxd_i != serial_port_pkg::parity_of(rx_byte, eight_bit_i,
                                                                  parity_i);
                next_rx_ph   = serial_port_pkg::PH_STOP;
              end
              serial_port_pkg::PH_STOP:
              begin
                // Only the first stop is checked; a second is idle time
                next_rx_ph = serial_port_pkg::PH_IDLE;
                if (rx_zero && !rxd_i)
                  next_brk = 1'b1;
                else if (!rxd_i)
                  next_frm = 1'b1;
                if (rx_perr)
                  next_par = 1'b1;
                if (rx_valid_o && !rx_read_i)
                  next_ovr = 1'b1;
                next_rx_data  = rx_byte;
                next_rx_valid = 1'b1;
              end
              default: next_rx_ph = serial_port_pkg::PH_IDLE;
            endcase
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      rx_ph      <= serial_port_pkg::PH_IDLE;
      rx_tk      <= '0;
      rx_bit     <= '0;
      rx_shift   <= serial_port_pkg::BYTE_RESET;
      rx_zero    <= 1'b0;
      rx_perr    <= 1'b0;
      rx_prev    <= 1'b1; // Idle level, so no false edge after reset
      rx_data_o  <= serial_port_pkg::BYTE_RESET;
      rx_valid_o <= 1'b0;
      brk_err_o  <= 1'b0;
      frm_err_o  <= 1'b0;
      par_err_o  <= 1'b0;
      ovr_err_o  <= 1'b0;
    end
    else
    begin
      rx_ph      <= next_rx_ph;
      rx_tk      <= next_rx_tk;
      rx_bit     <= next_rx_bit;
      rx_shift   <= next_rx_shift;
      rx_zero    <= next_rx_zero;
      rx_perr    <= next_rx_perr;
      rx_prev    <= next_rx_prev;
      rx_data_o  <= next_rx_data;
      rx_valid_o <= next_rx_valid;
      brk_err_o  <= next_brk;
      frm_err_o  <= next_frm;
      par_err_o  <= next_par;
      ovr_err_o  <= next_ovr;
    end
  end

  // One request line for all three event classes
  assign irq_o = (tx_irq_en_i & tx_done_o) | (rx_irq_en_i & rx_valid_o)
               | (err_irq_en_i & (brk_err_o | frm_err_o | par_err_o | ovr_err_o));

endmodule : async_serial_port

// ===== tb/serial_remote.sv
// Remote serial device model: drives the receive pin, captures the transmit pin
module serial_remote
#(
  parameter int BIT = 32  // Clocks per bit
)
(
  input  wire logic clk_i, // System clock
  input  wire logic txd_i, // Design transmit pin
  output logic      rxd_o  // Design receive pin
);
  timeunit 1ns;
  timeprecision 1ps;

  initial rxd_o = 1'b1;

  // Bits after the start bit, LSB first; unused places stay high as stops
  function automatic logic [11:0] frame(input logic [7:0] d, input int n, input logic [1:0] m);
    logic [11:0] f;
    f = 12'hfff;
    for (int k = 0; k < n; k++)
      f[k] = d[k];
    if (m != 2'h0)
      f[n] = ^(d & (n == 8 ? 8'hff : 8'h7f)) ^ (m == 2'h1);
    frame = f;
  endfunction : frame

  // Send one start bit and nb bits of f, changing at the falling edge
  task automatic send(input logic [11:0] f, input int nb);
    @(negedge clk_i);
    rxd_o = 1'b0;
    repeat (BIT) @(negedge clk_i);
    for (int k = 0; k < nb; k++)
    begin
      rxd_o = f[k];
      repeat (BIT) @(negedge clk_i);
    end
    rxd_o = 1'b1;
  endtask : send

  // Sample mid-bit after a falling start edge, away from the launching edge
  task automatic recv(input int nb, output logic [11:0] f);
    f = 12'hfff;
    @(negedge txd_i);
    repeat (BIT / 2) @(negedge clk_i);
    for (int k = 0; k < nb; k++)
    begin
      repeat (BIT) @(negedge clk_i);
      f[k] = txd_i;
    end
  endtask : recv
endmodule : serial_remote

// ===== tb/async_serial_port_assertions.sv
// Port checker for the asynchronous serial port
module async_serial_port_assertions
(
  input wire logic        clk_i,        // Clock
  input wire logic        srst_i,       // Reset
  input wire logic [15:0] divisor_i,    // Divisor
  input wire logic        eight_bit_i,  // Width
  input wire logic        err_irq_en_i, // Error enable
  input wire logic        tx_irq_en_i,  // Tx enable
  input wire logic        rx_irq_en_i,  // Rx enable
  input wire logic        tx_write_i,   // Tx load
  input wire logic        tx_ready_o,   // Tx free
  input wire logic        tx_done_o,    // Tx done
  input wire logic        txd_o,        // Tx pin
  input wire logic [7:0]  rx_data_o,    // Rx byte
  input wire logic        rx_valid_o,   // Rx full
  input wire logic        rx_read_i,    // Rx taken
  input wire logic        brk_err_o,    // Break
  input wire logic        frm_err_o,    // Framing
  input wire logic        par_err_o,    // Parity
  input wire logic        ovr_err_o,    // Overrun
  input wire logic        err_clr_i,    // Flag clear
  input wire logic        irq_o         // Interrupt
);
  default clocking dcb @(posedge clk_i);
  endclocking
  default disable iff (srst_i);

  logic [19:0] run_len, next_run_len, bit_min;
  logic        txd_q, next_txd_q;

  // Run length of txd; reset fills it so the first start edge passes
  always_comb
  begin
    next_txd_q = txd_o;
    next_run_len = (txd_o != txd_q) ? 20'h00001 : run_len + {19'h0, ~&run_len};
    if (srst_i)
      next_run_len = 20'hfffff;
    bit_min = {4'h0, divisor_i} * 20'h0000f + 20'h0000f; // Start may lose one tick
  end

  // Register helper state
  always_ff @(posedge clk_i)
  begin
    txd_q <= next_txd_q;
    run_len <= next_run_len;
  end

  chk_irq_sources: assert property (irq_o == ((tx_irq_en_i & tx_done_o) |
    (rx_irq_en_i & rx_valid_o) | (err_irq_en_i & (brk_err_o | frm_err_o | par_err_o | ovr_err_o))))
    else $error("irq does not follow enabled sources");
  chk_tx_accept: assert property (tx_write_i && tx_ready_o |=> !tx_ready_o)
    else $error("tx buffer still free after load");
  chk_bit_length: assert property ((txd_o != txd_q) |-> run_len >= bit_min)
    else $error("txd level shorter than a bit");
  chk_rx_hold: assert property (rx_valid_o && !rx_read_i |=> rx_valid_o)
    else $error("rx byte lost without read");
  chk_flags_sticky: assert property (!err_clr_i |=>
    ({brk_err_o, frm_err_o, par_err_o, ovr_err_o} & $past({brk_err_o, frm_err_o, par_err_o,
    ovr_err_o})) == $past({brk_err_o, frm_err_o, par_err_o, ovr_err_o}))
    else $error("error flag fell without clear");
  chk_brk_not_frm: assert property ($rose(brk_err_o) |-> !$rose(frm_err_o))
    else $error("break also flagged framing");
  chk_ovr_cause: assert property ($rose(ovr_err_o) |-> $past(rx_valid_o))
    else $error("overrun with empty buffer");
  chk_done_idle: assert property ($rose(tx_done_o) |-> txd_o)
    else $error("tx done while line low");
  chk_rx_seven: assert property (rx_valid_o && !eight_bit_i |-> !rx_data_o[7])
    else $error("bit 7 set in seven-bit mode");

  cov_overrun: cover property ($rose(ovr_err_o));
  cov_break: cover property ($rose(brk_err_o));
  cov_tx_done: cover property ($rose(tx_done_o));
endmodule : async_serial_port_assertions

bind async_serial_port async_serial_port_assertions u_async_serial_port_assertions
(
  .clk_i(clk_i), .srst_i(srst_i), .divisor_i(divisor_i), .eight_bit_i(eight_bit_i),
  .err_irq_en_i(err_irq_en_i), .tx_irq_en_i(tx_irq_en_i), .rx_irq_en_i(rx_irq_en_i),
  .tx_write_i(tx_write_i), .tx_ready_o(tx_ready_o), .tx_done_o(tx_done_o), .txd_o(txd_o),
  .rx_data_o(rx_data_o), .rx_valid_o(rx_valid_o), .rx_read_i(rx_read_i),
  .brk_err_o(brk_err_o), .frm_err_o(frm_err_o), .par_err_o(par_err_o),
  .ovr_err_o(ovr_err_o), .err_clr_i(err_clr_i), .irq_o(irq_o)
);

// ===== tb/async_serial_port_test.sv
// Self-checking bench for the asynchronous serial port
module async_serial_port_test;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int BIT = 32; // Divisor 1: two clocks a tick
  typedef struct {logic [7:0] d; logic e; logic [1:0] p; logic t;} row_s;

  logic        clk_i = 1'b0, srst_i = 1'b1, eight_bit_i = 1'b1, two_stop_i = 1'b0;
  logic [15:0] divisor_i = 16'h0001;
  logic [1:0]  parity_i = 2'h0;
  logic        err_irq_en_i = 1'b1, tx_irq_en_i = 1'b0, rx_irq_en_i = 1'b1;
  logic [7:0]  tx_data_i = 8'h00, rx_data_o;
  logic        tx_write_i = 1'b0, tx_done_clr_i = 1'b0, rx_read_i = 1'b0, err_clr_i = 1'b0;
  logic        tx_ready_o, tx_done_o, txd_o, rxd_i, rx_valid_o, irq_o;
  logic        brk_err_o, frm_err_o, par_err_o, ovr_err_o;
  logic [11:0] f, g;
  int          fail_count = 0, cmp_count = 0, n, nb;
  row_s        rows [4] = '{'{8'ha5, 1'b1, 2'h0, 1'b0}, '{8'h3c, 1'b0, 2'h1, 1'b1},
                            '{8'h81, 1'b1, 2'h2, 1'b1}, '{8'h56, 1'b1, 2'h1, 1'b0}};

  // 125 MHz clock
  always #4 clk_i = ~clk_i;

  async_serial_port u_async_serial_port
  (
    .clk_i(clk_i), .srst_i(srst_i), .divisor_i(divisor_i), .eight_bit_i(eight_bit_i),
    .parity_i(parity_i), .two_stop_i(two_stop_i), .err_irq_en_i(err_irq_en_i),
    .tx_irq_en_i(tx_irq_en_i), .rx_irq_en_i(rx_irq_en_i), .tx_data_i(tx_data_i),
    .tx_write_i(tx_write_i), .tx_ready_o(tx_ready_o), .tx_done_o(tx_done_o),
    .tx_done_clr_i(tx_done_clr_i), .txd_o(txd_o), .rxd_i(rxd_i), .rx_data_o(rx_data_o),
    .rx_valid_o(rx_valid_o), .rx_read_i(rx_read_i), .brk_err_o(brk_err_o),
    .frm_err_o(frm_err_o), .par_err_o(par_err_o), .ovr_err_o(ovr_err_o),
    .err_clr_i(err_clr_i), .irq_o(irq_o)
  );

  serial_remote #(.BIT(BIT)) u_serial_remote (.clk_i(clk_i), .txd_i(txd_o), .rxd_o(rxd_i));

  task automatic check(input string what, input logic [19:0] seen, input logic [19:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // One-cycle pulses: write, done clear, read, error clear
  task automatic strobe(input logic [3:0] m);
    @(negedge clk_i);
    {tx_write_i, tx_done_clr_i, rx_read_i, err_clr_i} = m;
    @(negedge clk_i);
    {tx_write_i, tx_done_clr_i, rx_read_i, err_clr_i} = 4'h0;
  endtask : strobe

  task automatic setup(input row_s r);
    eight_bit_i = r.e;
    parity_i = r.p;
    two_stop_i = r.t;
    n = r.e ? 8 : 7;
    f = u_serial_remote.frame(r.d, n, r.p);
    nb = n + int'(r.p != 2'h0) + 1 + int'(r.t);
  endtask : setup

  // Received byte and flags, then read and clear everything
  task automatic expect_rx(input logic [7:0] d, input logic [3:0] errs);
    check("rx valid", rx_valid_o, 1'b1);
    check("rx data", rx_data_o, d);
    check("rx flags", {brk_err_o, frm_err_o, par_err_o, ovr_err_o}, errs);
    strobe(4'h7);
  endtask : expect_rx

  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : finish_test

  // Watchdog well beyond the expected few thousand cycles
  initial
  begin
    repeat (20000) @(posedge clk_i);
    fail_count++;
    finish_test();
  end

  initial
  begin
    repeat (16) @(negedge clk_i);
    srst_i = 1'b0;
    @(negedge clk_i);
    check("reset state", {txd_o, tx_ready_o, rx_valid_o, tx_done_o, brk_err_o, frm_err_o,
          par_err_o, ovr_err_o, irq_o, rx_data_o}, 20'h18000);
    $display("reset test done");
    // Full duplex: each row sent and received at once
    for (int i = 0; i < 4; i++)
    begin
      setup(rows[i]);
      tx_data_i = rows[i].d;
      strobe(4'h8);
      fork
        u_serial_remote.recv(nb, g);
        u_serial_remote.send(f, nb);
      join
      check("tx frame", g, f);
      repeat (BIT) @(negedge clk_i);
      check("tx done", tx_done_o, 1'b1);
      check("rx irq", irq_o, 1'b1);
      expect_rx(rows[i].d & (n == 8 ? 8'hff : 8'h7f), 4'h0);
      check("irq idle", irq_o, 1'b0);
      $display("row %0d done", i);
    end
    // Parity error, masked then enabled
    rx_irq_en_i = 1'b0;
    err_irq_en_i = 1'b0;
    setup(rows[2]);
    f[8] = ~f[8];
    u_serial_remote.send(f, nb);
    check("masked irq", irq_o, 1'b0);
    err_irq_en_i = 1'b1;
    @(negedge clk_i);
    check("error irq", irq_o, 1'b1);
    expect_rx(8'h81, 4'h2);
    $display("parity test done");
    // Framing error, then break, then overrun
    setup(rows[0]);
    f[8] = 1'b0;
    u_serial_remote.send(f, nb);
    expect_rx(8'ha5, 4'h4);
    u_serial_remote.send(12'h000, nb);
    expect_rx(8'h00, 4'h8);
    u_serial_remote.send(u_serial_remote.frame(8'h11, 8, 2'h0), nb);
    u_serial_remote.send(u_serial_remote.frame(8'h22, 8, 2'h0), nb);
    expect_rx(8'h22, 4'h1);
    $display("error tests done");
    // Back-to-back loads, third refused while buffer full
    tx_data_i = 8'h5a;
    strobe(4'h8);
    fork
      begin
        u_serial_remote.recv(nb, g);
        check("first frame", g, u_serial_remote.frame(8'h5a, 8, 2'h0));
        u_serial_remote.recv(nb, g);
        check("second frame", g, u_serial_remote.frame(8'hc3, 8, 2'h0));
        repeat (BIT) @(negedge clk_i);
        check("refused load", txd_o, 1'b1);
      end
      begin
        repeat (2) @(negedge clk_i);
        tx_data_i = 8'hc3;
        strobe(4'h8);
        check("buffer full", tx_ready_o, 1'b0);
        tx_data_i = 8'hff;
        strobe(4'h8);
      end
    join
    $display("buffer test done");
    finish_test();
  end
endmodule : async_serial_port_test
